// file: core/ulcm_top.sv
`timescale 1ns/1ps
// Operation
// - orange indicator follows register 0x09, 0x01 on, 0x00 off, read/write.
// - green indicator follows register 0x0a, 0x01 on, 0x00 off, read/write.
// - blue indicator follows register 0x0b, 0x01 on, 0x00 off, read/write.
// - i2c target at 0x6b; index byte then value byte.
// - source masks at 0x17 orange, 0x18 green, 0x19 blue.
// - mask bits 0..7 select power, cell, charge, notice, cooler, switch, host, cable.
// - mapping never alters the system indicator outputs themselves.
// - direct writes still work; each system update overwrites a mapped indicator.
// - a mask may have two or more bits set.
// - power path source is ANDed with the power_path_blink input, which sets its on/off timing.
module ulcm_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] sys_status,
  input wire logic power_path_blink,
  output logic orange_led,
  output logic green_led,
  output logic blue_led
);
  // ************************************************************
  // reset release and pin synchronisers
  // ************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic scl_s_reg, sda_s_reg;
  assign rst_n = rst_sync_reg[1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  // change accepted when the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
      scl_s_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else if (ce) begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[2] == scl_sync_reg[1]) begin
        scl_s_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[2] == sda_sync_reg[1]) begin
        sda_s_reg <= sda_sync_reg[2];
      end
    end
  end
  // ************************************************************
  // i2c target
  // ************************************************************
  logic wr_stb;
  logic [7:0] wr_index, wr_data, rd_index;
  logic [7:0] rd_data;
  ulcm_i2c_target u_tgt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .scl_s(scl_s_reg),
    .sda_s(sda_s_reg),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .rd_index(rd_index),
    .rd_data(rd_data)
  );
  // open drain: value stays low, only the enable moves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctrl_reg [3];
  logic [7:0] mask_reg [3];
  logic [7:0] src_prev_reg;
  logic [7:0] sys_s1_reg, sys_s2_reg, sys_s3_reg, sys_reg;
  logic [7:0] src_eff;
  logic src_update;
  // a status bit moves only once the last two stages agree
  wire [7:0] sys_agree = ~(sys_s2_reg ^ sys_s3_reg);
  wire [7:0] ofs_ctrl [3] = '{ulcm_pkg::ULCM_OFS_ORANGE_CTRL,
    ulcm_pkg::ULCM_OFS_GREEN_CTRL, ulcm_pkg::ULCM_OFS_BLUE_CTRL};
  wire [7:0] ofs_mask [3] = '{ulcm_pkg::ULCM_OFS_ORANGE_MASK,
    ulcm_pkg::ULCM_OFS_GREEN_MASK, ulcm_pkg::ULCM_OFS_BLUE_MASK};
  // status pins are asynchronous, same 3-stage agreement filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_s1_reg <= 8'h00;
      sys_s2_reg <= 8'h00;
      sys_s3_reg <= 8'h00;
      sys_reg <= 8'h00;
      src_prev_reg <= 8'h00;
    end else if (ce) begin
      sys_s1_reg <= {sys_status[7:1], sys_status[0] & power_path_blink};
      sys_s2_reg <= sys_s1_reg;
      sys_s3_reg <= sys_s2_reg;
      sys_reg <= (sys_s3_reg & sys_agree) | (sys_reg & ~sys_agree);
      src_prev_reg <= src_eff;
    end
  end
  // power path bit arrives already carrying its own blink pattern
  // sources are only read here, never driven back
  assign src_eff = sys_reg;
  assign src_update = src_eff != src_prev_reg;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_led
      wire hit_ctrl = wr_stb && wr_index == ofs_ctrl[g];
      wire hit_mask = wr_stb && wr_index == ofs_mask[g];
      wire mapped = |mask_reg[g];
      wire mirror = |(mask_reg[g] & src_eff);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_reg[g] <= ulcm_pkg::ULCM_CTRL_RESET;
          mask_reg[g] <= ulcm_pkg::ULCM_MASK_RESET;
        end else if (ce) begin
          if (hit_mask) begin
            mask_reg[g] <= wr_data;
          end
          // a status update wins over a direct write in the same cycle
          if (mapped && src_update) begin
            ctrl_reg[g] <= {7'h00, mirror};
          end else if (hit_ctrl) begin
            ctrl_reg[g] <= wr_data;
          end
        end
      end
    end
  endgenerate
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (rd_index == ofs_ctrl[i]) begin
        rd_data = ctrl_reg[i];
      end
      if (rd_index == ofs_mask[i]) begin
        rd_data = mask_reg[i];
      end
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orange_led <= 1'b0;
      green_led <= 1'b0;
      blue_led <= 1'b0;
    end else if (ce) begin
      orange_led <= ctrl_reg[0][ulcm_pkg::ULCM_CTRL_ON_BIT];
      green_led <= ctrl_reg[1][ulcm_pkg::ULCM_CTRL_ON_BIT];
      blue_led <= ctrl_reg[2][ulcm_pkg::ULCM_CTRL_ON_BIT];
    end
  end
endmodule

// file: inc/ulcm_pkg.sv
package ulcm_pkg;
  // ************************************************************
  // bus address and register offsets
  // ************************************************************
  localparam logic [6:0] ULCM_I2C_ADDR = 7'h6b;
  localparam logic [7:0] ULCM_OFS_ORANGE_CTRL = 8'h09;
  localparam logic [7:0] ULCM_OFS_GREEN_CTRL = 8'h0a;
  localparam logic [7:0] ULCM_OFS_BLUE_CTRL = 8'h0b;
  localparam logic [7:0] ULCM_OFS_ORANGE_MASK = 8'h17;
  localparam logic [7:0] ULCM_OFS_GREEN_MASK = 8'h18;
  localparam logic [7:0] ULCM_OFS_BLUE_MASK = 8'h19;
  // ************************************************************
  // reset values and fields
  // ************************************************************
  localparam logic [7:0] ULCM_CTRL_RESET = 8'h00;
  localparam logic [7:0] ULCM_MASK_RESET = 8'h00;
  localparam int ULCM_CTRL_ON_BIT = 0;
  localparam int ULCM_SRC_POWER_PATH = 0;
  localparam int ULCM_SRC_CELL_LOW = 1;
  localparam int ULCM_SRC_CHARGING = 2;
  localparam int ULCM_SRC_NOTICE = 3;
  localparam int ULCM_SRC_COOLER = 4;
  localparam int ULCM_SRC_SWITCH = 5;
  localparam int ULCM_SRC_HOST_SUPPLY = 6;
  localparam int ULCM_SRC_CABLE = 7;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int ULCM_CLK_HZ = 20000000;
  localparam int ULCM_BLINK_MS = 400;
  localparam int ULCM_BLINK_CYC = ULCM_CLK_HZ / 1000 * ULCM_BLINK_MS;
endpackage

// file: core/ulcm_i2c_target.sv
`timescale 1ns/1ps
// i2c target: first byte after address is index, then data bytes;
// index steps only after value and read bytes, so a read after a repeated start returns it.
module ulcm_i2c_target (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data,
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {ULCM_IDLE, ULCM_ADDR, ULCM_AACK, ULCM_WBYTE, ULCM_WACK,
    ULCM_RBYTE, ULCM_RACK} ulcm_i2c_st_t;
  ulcm_i2c_st_t st_reg;
  logic scl_d_reg, sda_d_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic is_rd_reg, have_idx_reg;
  logic [7:0] idx_reg;
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [7:0] sh_in = {sh_reg[6:0], sda_s};
  wire addr_hit = sh_reg[7:1] == ulcm_pkg::ULCM_I2C_ADDR;
  assign rd_index = idx_reg;
  assign wr_index = idx_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ULCM_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      is_rd_reg <= 1'b0;
      have_idx_reg <= 1'b0;
      idx_reg <= 8'h00;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else if (ce) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      wr_stb <= 1'b0;
      if (start_c) begin
        st_reg <= ULCM_ADDR;
        cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
        have_idx_reg <= 1'b0;
      end else if (stop_c) begin
        st_reg <= ULCM_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (st_reg)
          ULCM_IDLE: ;
          ULCM_ADDR, ULCM_WBYTE: begin
            if (scl_rise) begin
              sh_reg <= sh_in;
              cnt_reg <= cnt_reg + 4'h1;
            end
            if (scl_fall && cnt_reg == 4'h8) begin
              if (st_reg == ULCM_ADDR) begin
                if (addr_hit) begin
                  sda_oe <= 1'b1;
                  is_rd_reg <= sh_reg[0];
                  st_reg <= ULCM_AACK;
                end else begin
                  st_reg <= ULCM_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                st_reg <= ULCM_WACK;
                // index byte first, then values
                if (!have_idx_reg) begin
                  idx_reg <= sh_reg;
                end else begin
                  wr_data <= sh_reg;
                  wr_stb <= 1'b1;
                end
              end
            end
          end
          ULCM_AACK, ULCM_WACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              sda_oe <= 1'b0;
              // step only after a value byte, so a value equal to the index is harmless
              if (st_reg == ULCM_WACK) begin
                have_idx_reg <= 1'b1;
                if (have_idx_reg) begin
                  idx_reg <= idx_reg + 8'h01;
                end
              end
              if (st_reg == ULCM_AACK && is_rd_reg) begin
                sh_reg <= rd_data;
                sda_oe <= ~rd_data[7];
                st_reg <= ULCM_RBYTE;
              end else begin
                st_reg <= ULCM_WBYTE;
              end
            end
          end
          ULCM_RBYTE: begin
            if (scl_fall) begin
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == 4'h7) begin
                sda_oe <= 1'b0;
                st_reg <= ULCM_RACK;
              end else begin
                sda_oe <= ~sh_reg[6];
                sh_reg <= {sh_reg[6:0], 1'b0};
              end
            end
          end
          ULCM_RACK: begin
            if (scl_rise) begin
              is_rd_reg <= ~sda_s;
            end
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (is_rd_reg) begin
                sh_reg <= rd_data;
                sda_oe <= ~rd_data[7];
                st_reg <= ULCM_RBYTE;
              end else begin
                st_reg <= ULCM_IDLE;
              end
            end
          end
          default: st_reg <= ULCM_IDLE;
        endcase
        if (st_reg == ULCM_RBYTE && scl_fall && cnt_reg == 4'h7) begin
          idx_reg <= idx_reg + 8'h01;
        end
      end
    end
  end
endmodule

// file: sim/ulcm_checker.sv
`timescale 1ns/1ps
module ulcm_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] sys_status,
  input wire logic power_path_blink,
  input wire logic orange_led,
  input wire logic green_led,
  input wire logic blue_led
);
  // ****
  // cycles since a cause; frozen clock restarts it
  // ****
  logic [3:0] quiet_reg;
  logic [9:0] prev_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_reg <= 4'h0;
      prev_reg <= 10'h000;
    end else begin
      prev_reg <= {scl_in, power_path_blink, sys_status};
      if (!ce || prev_reg != {scl_in, power_path_blink, sys_status}) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_leds_dark;
    !orange_led && !green_led && !blue_led;
  endsequence
  a_leds_reset_off: assert property ($rose(resetn) |-> s_leds_dark [*3])
    else $error("leds lit after reset");
  a_oe_reset_off: assert property ($rose(resetn) |-> !sda_oe [*4])
    else $error("data line pulled after reset");
  a_sda_out_zero: assert property (sda_out == 1'b0)
    else $error("data value not zero");
  a_ce_freeze: assert property (!ce |=> $stable({orange_led, green_led, blue_led, sda_oe}))
    else $error("outputs moved while frozen");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
  a_ack_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("data line pulled too soon");
  a_orange_cause: assert property ($changed(orange_led) |-> quiet_reg < 4'hf)
    else $error("orange moved without cause");
  a_green_cause: assert property ($changed(green_led) |-> quiet_reg < 4'hf)
    else $error("green moved without cause");
  a_blue_cause: assert property ($changed(blue_led) |-> quiet_reg < 4'hf)
    else $error("blue moved without cause");
endmodule
bind ulcm_top ulcm_checker ulcm_checker_i (.clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sys_status(sys_status),
  .power_path_blink(power_path_blink), .orange_led(orange_led), .green_led(green_led),
  .blue_led(blue_led));

// file: sim/ulcm_host_model.sv
`timescale 1ns/1ps
module ulcm_host_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_low = 1'b0;
  initial scl = 1'b1;
  // pull-up: high unless a party pulls low
  assign sda = !(sda_low || sda_oe);
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold(6);
    scl = 1'b1;
    hold(6);
    r = sda;
    hold(6);
    scl = 1'b0;
    hold(6);
  endtask
  task automatic start;
    sda_low = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(12);
    sda_low = 1'b1;
    hold(12);
    scl = 1'b0;
    hold(6);
  endtask
  task automatic stop;
    sda_low = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(12);
    sda_low = 1'b0;
    hold(12);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ai, r);
    a = !r;
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] idx, input logic [7:0] d,
    output logic [2:0] acks);
    logic [7:0] q;
    start;
    xfer({ad, 1'b0}, 1'b1, q, acks[2]);
    xfer(idx, 1'b1, q, acks[1]);
    xfer(d, 1'b1, q, acks[0]);
    stop;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic a;
    start;
    xfer({ulcm_pkg::ULCM_I2C_ADDR, 1'b0}, 1'b1, d, a);
    xfer(idx, 1'b1, d, a);
    start;
    xfer({ulcm_pkg::ULCM_I2C_ADDR, 1'b1}, 1'b1, d, a);
    xfer(8'hff, 1'b1, d, a); // no ack ends the read
    stop;
  endtask
endmodule

// file: sim/tb_ulcm_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module tb_ulcm_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sys_status = 8'h00;
  logic power_path_blink = 1'b1;
  logic scl, sda, sda_out, sda_oe, orange_led, green_led, blue_led;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] q;
  logic [2:0] acks;
  logic [7:0] mofs [3] = '{8'h17, 8'h18, 8'h19};
  wire [2:0] leds = {blue_led, green_led, orange_led};
  always #25 clk = ~clk;
  ulcm_host_model ulcm_host_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  ulcm_top ulcm_top_i (.clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sys_status(sys_status),
    .power_path_blink(power_path_blink), .orange_led(orange_led), .green_led(green_led),
    .blue_led(blue_led));
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ulcm_host_model_i.wr(ulcm_pkg::ULCM_I2C_ADDR, idx, d, acks);
    `CHK("ack", 3'b111, acks)
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    ulcm_host_model_i.rd(idx, q);
    `CHK("read", e, q)
  endtask
  // status settles through the input synchroniser
  task automatic stat(input logic [7:0] s, input logic bl);
    @(posedge clk);
    #5;
    sys_status = s;
    power_path_blink = bl;
    repeat (10) @(posedge clk);
    #5;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    #5;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #5;
    `CHK("leds", 3'b000, leds)
    `CHK("sda_out", 1'b0, sda_out)
    for (int k = 0; k < 3; k++) begin
      rdchk(8'h09 + 8'(k), 8'h00);
      rdchk(mofs[k], 8'h00);
      wr(8'h09 + 8'(k), 8'h01);
      `CHK("on", 3'b001 << k, leds)
      rdchk(8'h09 + 8'(k), 8'h01);
      wr(8'h09 + 8'(k), 8'h00);
      `CHK("off", 3'b000, leds)
      for (int b = 0; b < 8; b++) begin
        wr(mofs[k], 8'h01 << b);
        stat(8'hff ^ (8'h01 << b), 1'b1);
        `CHK("unsel", 3'b000, leds)
        stat(8'h01 << b, 1'b1);
        `CHK("sel", 3'b001 << k, leds)
      end
      stat(8'h00, 1'b1);
      wr(mofs[k], 8'h00);
    end
    wr(8'h17, 8'h83);
    stat(8'h02, 1'b1);
    `CHK("or", 3'b001, leds)
    wr(8'h09, 8'h00);
    `CHK("direct", 3'b000, leds)
    stat(8'h06, 1'b1);
    `CHK("overwrite", 3'b001, leds)
    stat(8'h01, 1'b0);
    `CHK("blink low", 3'b000, leds)
    stat(8'h81, 1'b0);
    `CHK("or cable", 3'b001, leds)
    rdchk(8'h17, 8'h83);
    ce = 1'b0;
    stat(8'h00, 1'b1);
    `CHK("frozen", 3'b001, leds)
    ce = 1'b1;
    repeat (10) @(posedge clk);
    #5;
    `CHK("thawed", 3'b000, leds)
    wr(8'h0c, 8'h5a);
    rdchk(8'h0c, 8'h00);
    ulcm_host_model_i.wr(7'h2a, 8'h0a, 8'h01, acks);
    `CHK("nack", 3'b000, acks)
    `CHK("ignored", 3'b000, leds)
    end_of_test;
  end
endmodule
